// File: hw/bbfe_pkg.sv
// Constants and types for the branch, bit and flag execution slice.
// Assumes a single clock domain; shared by the core and its flag unit.
package bbfe_pkg;

   // Status flag positions
   localparam int unsigned FLG_C = 0;
   localparam int unsigned FLG_Z = 1;
   localparam int unsigned FLG_N = 2;
   localparam int unsigned FLG_V = 3;
   localparam int unsigned FLG_S = 4;
   localparam int unsigned FLG_H = 5;
   localparam int unsigned FLG_T = 6;
   localparam int unsigned FLG_I = 7;

   localparam int unsigned DATA_W      = 8;
   localparam int unsigned BIT_SEL_W   = 3;
   localparam int unsigned OP_W        = 5;
   localparam logic [7:0]  FLAGS_RESET = 8'h00;

   // Cycle counts per instruction class
   localparam int unsigned CYC_SINGLE    = 1;
   localparam int unsigned CYC_BR_TAKEN  = 2;
   localparam int unsigned CYC_IO_BIT    = 2;

   typedef enum logic [4:0] {
      OP_NOP                  = 5'h00,
      OP_BRANCH_SIGNED_GE     = 5'h01,
      OP_BRANCH_SIGNED_LT     = 5'h02,
      OP_BRANCH_HALF_CARRY_ONE  = 5'h03,
      OP_BRANCH_HALF_CARRY_ZERO = 5'h04,
      OP_BRANCH_TRANSFER_ONE  = 5'h05,
      OP_BRANCH_TRANSFER_ZERO = 5'h06,
      OP_BRANCH_OVERFLOW_ONE  = 5'h07,
      OP_BRANCH_OVERFLOW_ZERO = 5'h08,
      OP_BRANCH_IRQ_ON        = 5'h09,
      OP_BRANCH_IRQ_OFF       = 5'h0a,
      OP_IO_BIT_SET           = 5'h0b,
      OP_IO_BIT_CLEAR         = 5'h0c,
      OP_ROTATE_LEFT_CARRY    = 5'h0d,
      OP_ROTATE_RIGHT_CARRY   = 5'h0e,
      OP_BIT_TO_TRANSFER_FLAG = 5'h0f,
      OP_TRANSFER_FLAG_TO_BIT = 5'h10,
      OP_SIGN_FLAG_SET        = 5'h11,
      OP_SIGN_FLAG_CLEAR      = 5'h12,
      OP_OVF_FLAG_SET         = 5'h13,
      OP_OVF_FLAG_CLEAR       = 5'h14,
      OP_HALF_CARRY_SET       = 5'h15,
      OP_HALF_CARRY_CLEAR     = 5'h16
   } bbfe_op_e;

   typedef enum logic [1:0] {
      ST_IDLE = 2'b00,
      ST_HOLD = 2'b01
   } bbfe_state_e;

endpackage

// File: hw/bbfe_flag_if.sv
// Link between the execution core and the status flag unit.
// Assumes both ends share one clock; writes are masked per flag.
`timescale 1ns/1ns
`default_nettype none
interface bbfe_flag_if;
   logic       wr_en;
   logic [7:0] wr_mask;
   logic [7:0] wr_val;
   logic [7:0] flags;

   modport core  (output wr_en, output wr_mask, output wr_val, input flags);
   modport store (input wr_en, input wr_mask, input wr_val, output flags);
endinterface
`default_nettype wire

// File: hw/bbfe_flags.sv
// Status flag register of the execution slice.
// Assumes a synchronous active-high reset; masked bits keep their value.
`timescale 1ns/1ns
`default_nettype none
module bbfe_flags (
   // Clock and reset
   input  wire logic   clk,
   input  wire logic   reset,
   // Core side
   bbfe_flag_if.store  fl
);
   logic [7:0] flags_reg;

   always_ff @(posedge clk) begin
      if (reset) begin
         flags_reg <= bbfe_pkg::FLAGS_RESET;
      end else if (fl.wr_en) begin
         flags_reg <= (flags_reg & ~fl.wr_mask) | (fl.wr_val & fl.wr_mask);
      end
   end

   assign fl.flags = flags_reg;
endmodule
`default_nettype wire

// File: hw/bbfe_exec.sv
// Execution core for conditional flag branches, I/O bit set and clear,
// rotates through carry, transfer-bit moves and explicit flag set/clear.
// Assumes the caller presents an instruction with its register and I/O
// operand values already read, and honours op_ready.
//
// Summary of operation
// - Signed greater-or-equal branch jumps to PC+k+1 when N xor V is 0, 1 or 2 cycles, no flags.
// - Signed less-than branch jumps to PC+k+1 when N xor V is 1, 1 or 2 cycles, no flags.
// - Half carry branches jump when H is 1 or 0 per variant, 1 or 2 cycles, no flags.
// - Transfer branches jump when T is 1 or 0 per variant, 1 or 2 cycles, no flags.
// - Overflow branches jump when V is 1 or 0 per variant, 1 or 2 cycles, no flags.
// - Interrupt branches jump when I is 1 or 0 per variant, 1 or 2 cycles, no flags.
// - I/O bit set forces the chosen bit to one, keeps the rest and the flags, in 2 cycles.
// - I/O bit clear forces the chosen bit to zero, keeps the rest and the flags, in 2 cycles.
// - Rotate left moves carry into bit 0 and bit 7 into carry, updating Z C N V in 1 cycle.
// - Rotate right moves carry into bit 7 and bit 0 into carry, updating Z C N V in 1 cycle.
// - Bit store copies the chosen register bit into T only, in 1 cycle.
// - Bit load writes T into the chosen register bit, leaving all else, in 1 cycle.
// - Dedicated single-cycle ops set or clear S and touch no other flag.
// - Dedicated single-cycle ops set or clear V and touch no other flag.
// - Dedicated single-cycle ops set or clear H and touch no other flag.
`timescale 1ns/1ns
`default_nettype none
module bbfe_exec #(
   parameter int unsigned PC_W   = 16,
   parameter int unsigned K_W    = 7,
   parameter int unsigned IOA_W  = 5
) (
   // Clock and reset
   input  wire logic                                  clk,
   input  wire logic                                  reset,
   // Instruction request
   input  wire logic                                  op_valid,
   input  wire logic [bbfe_pkg::OP_W-1:0]             op_code,
   input  wire logic [K_W-1:0]                        op_offset,
   input  wire logic [bbfe_pkg::BIT_SEL_W-1:0]        op_bit,
   input  wire logic [IOA_W-1:0]                      op_io_addr,
   input  wire logic [bbfe_pkg::DATA_W-1:0]           op_reg_data,
   input  wire logic [bbfe_pkg::DATA_W-1:0]           io_rd_data,
   output logic                                       op_ready,
   // Program counter
   output logic [PC_W-1:0]                            pc,
   // Working register write
   output logic                                       reg_wr_en,
   output logic [bbfe_pkg::DATA_W-1:0]                reg_wr_data,
   // I/O register write
   output logic                                       io_wr_en,
   output logic [IOA_W-1:0]                           io_wr_addr,
   output logic [bbfe_pkg::DATA_W-1:0]                io_wr_data,
   // Status flags
   output logic [7:0]                                 status_flags
);

   bbfe_flag_if fl ();

   bbfe_flags u_flags (
      .clk   (clk),
      .reset (reset),
      .fl    (fl)
   );

   bbfe_pkg::bbfe_state_e state_reg;
   bbfe_pkg::bbfe_op_e    op;
   logic                  accept;
   logic                  is_branch;
   logic                  taken;
   logic [PC_W-1:0]       pc_reg;
   logic [PC_W-1:0]       pc_next;
   logic [PC_W-1:0]       offset_ext;
   logic                  op_ready_reg;
   logic                  reg_wr_en_reg;
   logic [7:0]            reg_wr_data_reg;
   logic [7:0]            reg_wr_data_next;
   logic                  reg_wr_next;
   logic                  io_wr_en_reg;
   logic [IOA_W-1:0]      io_wr_addr_reg;
   logic [7:0]            io_wr_data_reg;
   logic [7:0]            fl_mask;
   logic [7:0]            fl_val;
   logic [7:0]            rot;
   logic                  rot_c;

   // Condition of a flag branch, taken from the flags before this op
   function automatic logic branch_cond(input bbfe_pkg::bbfe_op_e o, input logic [7:0] f);
      logic sv;
      sv = f[bbfe_pkg::FLG_N] ^ f[bbfe_pkg::FLG_V];
      case (o)
         bbfe_pkg::OP_BRANCH_SIGNED_GE:       branch_cond = ~sv;
         bbfe_pkg::OP_BRANCH_SIGNED_LT:       branch_cond = sv;
         bbfe_pkg::OP_BRANCH_HALF_CARRY_ONE:  branch_cond = f[bbfe_pkg::FLG_H];
         bbfe_pkg::OP_BRANCH_HALF_CARRY_ZERO: branch_cond = ~f[bbfe_pkg::FLG_H];
         bbfe_pkg::OP_BRANCH_TRANSFER_ONE:    branch_cond = f[bbfe_pkg::FLG_T];
         bbfe_pkg::OP_BRANCH_TRANSFER_ZERO:   branch_cond = ~f[bbfe_pkg::FLG_T];
         bbfe_pkg::OP_BRANCH_OVERFLOW_ONE:    branch_cond = f[bbfe_pkg::FLG_V];
         bbfe_pkg::OP_BRANCH_OVERFLOW_ZERO:   branch_cond = ~f[bbfe_pkg::FLG_V];
         bbfe_pkg::OP_BRANCH_IRQ_ON:          branch_cond = f[bbfe_pkg::FLG_I];
         bbfe_pkg::OP_BRANCH_IRQ_OFF:         branch_cond = ~f[bbfe_pkg::FLG_I];
         default:                             branch_cond = 1'b0;
      endcase
   endfunction

   // One-hot mask of a selected bit
   function automatic logic [7:0] bit_mask(input logic [2:0] b);
      bit_mask = 8'h01 << b;
   endfunction

   assign op        = bbfe_pkg::bbfe_op_e'(op_code);
   assign accept    = op_valid && op_ready_reg;
   assign is_branch = (op >= bbfe_pkg::OP_BRANCH_SIGNED_GE) &&
                      (op <= bbfe_pkg::OP_BRANCH_IRQ_OFF);
   assign taken     = is_branch && branch_cond(op, fl.flags);

   // Sign extension lets a branch reach backwards as well as forwards
   assign offset_ext = {{(PC_W-K_W){op_offset[K_W-1]}}, op_offset};
   assign pc_next    = taken ? pc_reg + offset_ext + PC_W'(1) : pc_reg + PC_W'(1);

   // Rotate result and carry out
   always_comb begin
      if (op == bbfe_pkg::OP_ROTATE_LEFT_CARRY) begin
         rot   = {op_reg_data[6:0], fl.flags[bbfe_pkg::FLG_C]};
         rot_c = op_reg_data[7];
      end else begin
         rot   = {fl.flags[bbfe_pkg::FLG_C], op_reg_data[7:1]};
         rot_c = op_reg_data[0];
      end
   end

   // Flag update and register result per opcode
   always_comb begin
      fl_mask          = 8'h00;
      fl_val           = 8'h00;
      reg_wr_next      = 1'b0;
      reg_wr_data_next = op_reg_data;
      case (op)
         bbfe_pkg::OP_ROTATE_LEFT_CARRY,
         bbfe_pkg::OP_ROTATE_RIGHT_CARRY: begin
            // Only Z, C, N and V move; S is left to its own instructions
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_Z)) | bit_mask(3'(bbfe_pkg::FLG_C)) |
                      bit_mask(3'(bbfe_pkg::FLG_N)) | bit_mask(3'(bbfe_pkg::FLG_V));
            fl_val[bbfe_pkg::FLG_Z] = (rot == 8'h00);
            fl_val[bbfe_pkg::FLG_C] = rot_c;
            fl_val[bbfe_pkg::FLG_N] = rot[7];
            fl_val[bbfe_pkg::FLG_V] = rot[7] ^ rot_c;
            reg_wr_next      = 1'b1;
            reg_wr_data_next = rot;
         end
         bbfe_pkg::OP_BIT_TO_TRANSFER_FLAG: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_T));
            fl_val[bbfe_pkg::FLG_T] = op_reg_data[op_bit];
         end
         bbfe_pkg::OP_TRANSFER_FLAG_TO_BIT: begin
            reg_wr_next      = 1'b1;
            reg_wr_data_next = fl.flags[bbfe_pkg::FLG_T] ? (op_reg_data | bit_mask(op_bit))
                                                         : (op_reg_data & ~bit_mask(op_bit));
         end
         bbfe_pkg::OP_SIGN_FLAG_SET: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_S));
            fl_val  = bit_mask(3'(bbfe_pkg::FLG_S));
         end
         bbfe_pkg::OP_SIGN_FLAG_CLEAR: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_S));
         end
         bbfe_pkg::OP_OVF_FLAG_SET: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_V));
            fl_val  = bit_mask(3'(bbfe_pkg::FLG_V));
         end
         bbfe_pkg::OP_OVF_FLAG_CLEAR: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_V));
         end
         bbfe_pkg::OP_HALF_CARRY_SET: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_H));
            fl_val  = bit_mask(3'(bbfe_pkg::FLG_H));
         end
         bbfe_pkg::OP_HALF_CARRY_CLEAR: begin
            fl_mask = bit_mask(3'(bbfe_pkg::FLG_H));
         end
         default: begin
            fl_mask = 8'h00;
         end
      endcase
   end

   // Branches and I/O bit ops never reach this write port
   assign fl.wr_en   = accept && (fl_mask != 8'h00);
   assign fl.wr_mask = fl_mask;
   assign fl.wr_val  = fl_val;

   // Program counter
   always_ff @(posedge clk) begin
      if (reset) begin
         pc_reg <= '0;
      end else if (accept) begin
         pc_reg <= pc_next;
      end
   end

   // Second cycle of a taken branch or an I/O bit op holds off the next op
   always_ff @(posedge clk) begin
      if (reset) begin
         state_reg    <= bbfe_pkg::ST_IDLE;
         op_ready_reg <= 1'b1;
      end else begin
         case (state_reg)
            bbfe_pkg::ST_IDLE: begin
               if (accept && (taken || op == bbfe_pkg::OP_IO_BIT_SET ||
                              op == bbfe_pkg::OP_IO_BIT_CLEAR)) begin
                  state_reg    <= bbfe_pkg::ST_HOLD;
                  op_ready_reg <= 1'b0;
               end
            end
            bbfe_pkg::ST_HOLD: begin
               state_reg    <= bbfe_pkg::ST_IDLE;
               op_ready_reg <= 1'b1;
            end
            default: begin
               state_reg    <= bbfe_pkg::ST_IDLE;
               op_ready_reg <= 1'b1;
            end
         endcase
      end
   end

   // I/O read-modify-write; the write lands in the op's second cycle
   always_ff @(posedge clk) begin
      if (reset) begin
         io_wr_en_reg   <= 1'b0;
         io_wr_addr_reg <= '0;
         io_wr_data_reg <= 8'h00;
      end else begin
         io_wr_en_reg <= accept && (op == bbfe_pkg::OP_IO_BIT_SET ||
                                    op == bbfe_pkg::OP_IO_BIT_CLEAR);
         if (accept && op == bbfe_pkg::OP_IO_BIT_SET) begin
            io_wr_addr_reg <= op_io_addr;
            io_wr_data_reg <= io_rd_data | bit_mask(op_bit);
         end else if (accept && op == bbfe_pkg::OP_IO_BIT_CLEAR) begin
            io_wr_addr_reg <= op_io_addr;
            io_wr_data_reg <= io_rd_data & ~bit_mask(op_bit);
         end
      end
   end

   // Working register write-back
   always_ff @(posedge clk) begin
      if (reset) begin
         reg_wr_en_reg   <= 1'b0;
         reg_wr_data_reg <= 8'h00;
      end else begin
         reg_wr_en_reg <= accept && reg_wr_next;
         if (accept && reg_wr_next) begin
            reg_wr_data_reg <= reg_wr_data_next;
         end
      end
   end

   assign op_ready     = op_ready_reg;
   assign pc           = pc_reg;
   assign reg_wr_en    = reg_wr_en_reg;
   assign reg_wr_data  = reg_wr_data_reg;
   assign io_wr_en     = io_wr_en_reg;
   assign io_wr_addr   = io_wr_addr_reg;
   assign io_wr_data   = io_wr_data_reg;
   assign status_flags = fl.flags;

endmodule
`default_nettype wire

// File: testbench/bbfe_exec_checker.sv
// Concurrent checks on the ports of the branch, bit and flag execution core.
// Assumes one clock domain and bbfe_exec ports with their default meaning.
`timescale 1ns/1ns
`default_nettype none
module bbfe_exec_checker #(
   parameter int unsigned PC_W  = 16,
   parameter int unsigned K_W   = 7,
   parameter int unsigned IOA_W = 5
) (
   // Clock and reset
   input wire logic             clk,
   input wire logic             reset,
   // Request side
   input wire logic             op_valid,
   input wire logic [4:0]       op_code,
   input wire logic [K_W-1:0]   op_offset,
   input wire logic [2:0]       op_bit,
   input wire logic [IOA_W-1:0] op_io_addr,
   input wire logic [7:0]       op_reg_data,
   input wire logic [7:0]       io_rd_data,
   // Result side
   input wire logic             op_ready,
   input wire logic [PC_W-1:0]  pc,
   input wire logic             reg_wr_en,
   input wire logic [7:0]       reg_wr_data,
   input wire logic             io_wr_en,
   input wire logic [IOA_W-1:0] io_wr_addr,
   input wire logic [7:0]       io_wr_data,
   input wire logic [7:0]       status_flags
);
   logic [7:0]      f, msk, rot, iox, bstf, bldv, setf;
   logic [3:0]      f_hi;
   logic            take, isbr, hit, rotc;
   logic [PC_W-1:0] tgt;
   assign f    = status_flags;
   assign f_hi = f[7:4];
   // Core ignores a request on its last reset edge; disable iff misses that edge
   assign take = op_valid && op_ready && !reset;
   assign isbr = op_code >= 5'h01 && op_code <= 5'h0a;
   assign msk  = 8'h01 << op_bit;
   // Target wraps at the counter width, as the core does
   assign tgt  = pc + {{(PC_W-K_W){op_offset[K_W-1]}}, op_offset} + 1'b1;
   assign rot  = op_code[0] ? {op_reg_data[6:0], f[0]} : {f[0], op_reg_data[7:1]};
   assign rotc = op_code[0] ? op_reg_data[7] : op_reg_data[0];
   assign iox  = op_code[0] ? io_rd_data | msk : io_rd_data & ~msk;
   assign bstf = {f[7], |(op_reg_data & msk), f[5:0]};
   assign bldv = f[6] ? op_reg_data | msk : op_reg_data & ~msk;
   always_comb begin
      setf = f;
      hit  = 1'b0;
      case (op_code)
         5'h01: hit = !(f[2] ^ f[3]);
         5'h02: hit = f[2] ^ f[3];
         5'h03: hit = f[5];
         5'h04: hit = !f[5];
         5'h05: hit = f[6];
         5'h06: hit = !f[6];
         5'h07: hit = f[3];
         5'h08: hit = !f[3];
         5'h09: hit = f[7];
         5'h0a: hit = !f[7];
         5'h11, 5'h12: setf[4] = op_code[0];
         5'h13, 5'h14: setf[3] = op_code[0];
         5'h15, 5'h16: setf[5] = op_code[0];
         default: hit = 1'b0;
      endcase
   end
   default clocking cb @(posedge clk); endclocking
   default disable iff (reset);
   sequence s_stall;
      !op_ready ##1 op_ready;
   endsequence
   a_ge_jump: assert property (take && op_code == 5'h01 |=>
      pc == ($past(hit) ? $past(tgt) : $past(pc) + 1'b1)) else $error("ge branch pc wrong");
   a_lt_jump: assert property (take && op_code == 5'h02 |=>
      pc == ($past(hit) ? $past(tgt) : $past(pc) + 1'b1)) else $error("lt branch pc wrong");
   a_flag_jump: assert property (take && op_code inside {[5'h03:5'h0a]} && hit |=>
      pc == $past(tgt) ##0 s_stall) else $error("flag branch jump wrong");
   a_br_fall: assert property (take && isbr && !hit |=>
      op_ready && pc == $past(pc) + 1'b1) else $error("untaken branch wrong");
   a_br_flags: assert property (take && isbr |=> $stable(status_flags))
      else $error("branch changed flags");
   a_io_rmw: assert property (take && op_code inside {5'h0b, 5'h0c} |=>
      io_wr_en && io_wr_addr == $past(op_io_addr) && io_wr_data == $past(iox)
      && $stable(status_flags) ##0 s_stall ##0 !io_wr_en) else $error("io bit write wrong");
   a_rot_flags: assert property (take && op_code inside {5'h0d, 5'h0e} |=>
      reg_wr_en && reg_wr_data == $past(rot) && f[0] == $past(rotc) && f[1] == (reg_wr_data == 8'h00)
      && f[2] == reg_wr_data[7] && f[3] == (f[2] ^ f[0]) && $stable(f_hi)) else $error("rotate wrong");
   a_bst_t: assert property (take && op_code == 5'h0f |=> status_flags == $past(bstf))
      else $error("bit store wrong");
   a_bld_bit: assert property (take && op_code == 5'h10 |=>
      reg_wr_en && reg_wr_data == $past(bldv) && $stable(status_flags)) else $error("bit load wrong");
   a_flag_ops: assert property (take && op_code inside {[5'h11:5'h16]} |=>
      status_flags == $past(setf)) else $error("flag op wrong");
endmodule
bind bbfe_exec bbfe_exec_checker #(.PC_W(PC_W), .K_W(K_W), .IOA_W(IOA_W)) u_chk (
   .clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code), .op_offset(op_offset),
   .op_bit(op_bit), .op_io_addr(op_io_addr), .op_reg_data(op_reg_data), .io_rd_data(io_rd_data),
   .op_ready(op_ready), .pc(pc), .reg_wr_en(reg_wr_en), .reg_wr_data(reg_wr_data),
   .io_wr_en(io_wr_en), .io_wr_addr(io_wr_addr), .io_wr_data(io_wr_data),
   .status_flags(status_flags));
`default_nettype wire

// File: testbench/branch_bitop_flag_exec_bench.sv
// Self-checking bench for the execution core with a cycle reference model.
// Assumes default core parameters; a request is offered on every edge of the first 64, then on about seven edges in eight.
`timescale 1ns/1ns
`default_nettype none
module branch_bitop_flag_exec_bench;
   logic        clk = 1'b0, reset = 1'b1, op_valid = 1'b0;
   logic [4:0]  op_code = 5'h00, op_io_addr = 5'h00, io_wr_addr, e_iwa;
   logic [6:0]  op_offset = 7'h00;
   logic [2:0]  op_bit = 3'h0;
   logic [7:0]  op_reg_data = 8'h00, io_rd_data = 8'h00, reg_wr_data, io_wr_data, status_flags;
   logic [7:0]  e_fl, e_rwd, e_iwd, m;
   logic [15:0] pc, e_pc;
   logic        op_ready, reg_wr_en, io_wr_en, e_rdy, e_rwe, e_iwe, c;
   logic [31:0] rnd = 32'h77fa;
   int          error_cnt = 0, compares = 0, i;
   always #2 clk = ~clk;
   bbfe_exec u_dut (.clk(clk), .reset(reset), .op_valid(op_valid), .op_code(op_code),
      .op_offset(op_offset), .op_bit(op_bit), .op_io_addr(op_io_addr), .op_reg_data(op_reg_data),
      .io_rd_data(io_rd_data), .op_ready(op_ready), .pc(pc), .reg_wr_en(reg_wr_en),
      .reg_wr_data(reg_wr_data), .io_wr_en(io_wr_en), .io_wr_addr(io_wr_addr),
      .io_wr_data(io_wr_data), .status_flags(status_flags));
   function automatic logic [31:0] lfsr(input logic [31:0] x);
      return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
   endfunction
   function automatic logic br_hit(input logic [4:0] op, input logic [7:0] f);
      case (op)
         5'h01: return !(f[2] ^ f[3]);
         5'h02: return f[2] ^ f[3];
         5'h03, 5'h04: return f[5] == op[0];
         5'h05, 5'h06: return f[6] == op[0];
         5'h07, 5'h08: return f[3] == op[0];
         5'h09, 5'h0a: return f[7] == op[0];
         default: return 1'b0;
      endcase
   endfunction
   task automatic check(input logic [15:0] seen, input logic [15:0] exp);
      compares++;
      if (seen !== exp) begin
         error_cnt++;
         $display("[ERR] %0t mismatch seen %h expected %h", $time, seen, exp);
      end
   endtask
   task automatic end_sim;
      $display("compares %0d error_cnt %0d", compares, error_cnt);
      if (error_cnt == 0 && compares > 0) begin
         $display("[ PASS ]");
      end else begin
         $display("[ FAIL ]");
      end
      $finish;
   endtask
   // Model reads inputs before the driver's updates land, like the core
   always @(posedge clk) begin
      e_rwe = 1'b0;
      e_iwe = 1'b0;
      m = 8'h01 << op_bit;
      if (reset) begin
         e_pc = 16'h0000;
         e_fl = 8'h00;
         e_rdy = 1'b1;
         e_rwd = 8'h00;
         e_iwd = 8'h00;
         e_iwa = 5'h00;
      end else if (!e_rdy) begin
         e_rdy = 1'b1;
      end else if (op_valid) begin
         e_pc = e_pc + 16'h0001;
         case (op_code)
            5'h0b, 5'h0c: begin
               e_iwe = 1'b1;
               e_iwa = op_io_addr;
               e_iwd = op_code[0] ? io_rd_data | m : io_rd_data & ~m;
               e_rdy = 1'b0;
            end
            5'h0d, 5'h0e: begin
               c = op_code[0] ? op_reg_data[7] : op_reg_data[0];
               e_rwd = op_code[0] ? {op_reg_data[6:0], e_fl[0]} : {e_fl[0], op_reg_data[7:1]};
               e_rwe = 1'b1;
               e_fl[3:0] = {e_rwd[7] ^ c, e_rwd[7], e_rwd == 8'h00, c};
            end
            5'h0f: e_fl[6] = |(op_reg_data & m);
            5'h10: begin
               e_rwe = 1'b1;
               e_rwd = e_fl[6] ? op_reg_data | m : op_reg_data & ~m;
            end
            5'h11, 5'h12: e_fl[4] = op_code[0];
            5'h13, 5'h14: e_fl[3] = op_code[0];
            5'h15, 5'h16: e_fl[5] = op_code[0];
            default: if (br_hit(op_code, e_fl)) begin
               e_pc = e_pc + {{9{op_offset[6]}}, op_offset};
               e_rdy = 1'b0;
            end
         endcase
      end
   end
   always @(negedge clk) if (!reset) begin
      check(pc, e_pc);
      check(status_flags, e_fl);
      check(op_ready, e_rdy);
      check(reg_wr_en, e_rwe);
      check(reg_wr_data, e_rwd);
      check(io_wr_en, e_iwe);
      check(io_wr_addr, e_iwa);
      check(io_wr_data, e_iwd);
   end
   // Opening pass walks every code with extreme offsets and zero-edge rotates
   initial begin
      repeat (19) @(posedge clk);
      for (i = 0; i < 3000; i++) begin
         @(posedge clk);
         rnd = lfsr(rnd);
         reset <= (i >= 1500 && i < 1503);
         op_valid <= i < 64 || rnd[31:29] != 3'h0;
         op_code <= i < 64 ? 5'(i % 23) : rnd[4:0];
         op_offset <= i < 64 ? {i[0], {6{~i[0]}}} : rnd[11:5];
         op_bit <= rnd[14:12];
         op_io_addr <= rnd[19:15];
         op_reg_data <= i < 64 ? {i[1], 6'h00, i[2]} : rnd[27:20];
         io_rd_data <= rnd[23:16] ^ rnd[31:24];
      end
      end_sim;
   end
endmodule
`default_nettype wire
